// >>> rtl/tmcap_core.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tmcap_params.svh"

// Notes on behaviour
// - Capture value is two bytes, high 15:8 and low 7:0, reset zero.
// - Each capture trigger outside capture-as-top modes copies the counter value into the capture value.
// - Sixteen-bit access goes through one shared temporary high-byte latch.
// - Capture value may act as counter top when the waveform mode selects it.
// - Capture interrupt needs mask bit 5, global enable and capture flag.
// - Compare B interrupt needs mask bit 2, global enable and its flag.
// - Compare A interrupt needs mask bit 1, global enable and its flag.
// - Overflow interrupt needs mask bit 0, global enable and its flag.
// - Capture flag, bit 5, sets on every capture event outside capture-as-top modes.
// - With capture value as top, capture flag sets when counter reaches it.
// - Flags clear on vector execution or on writing one; zero leaves them.
// - Compare B flag sets one timer tick after counter equals compare B.
// - Compare A flag sets one timer tick after counter equals compare A.
// - Forced compare strobes never set compare flags.
// - Overflow flag, bit 0, sets on the counter overflow event.
// - While sync mode bit 7 is one, prescaler reset value is kept.
// - Writing sync mode zero clears prescaler reset, counter resumes.
// - Prescaler reset bit 0 resets prescaler, self-clears unless sync mode.
// - Route bit 1 picks default or alternate pin set for timer pins.
// - Comparator capture select feeds comparator output into capture front.
module tmcap_core #(
	parameter int NC_SAMPLES = `TMCAP_NC_SAMPLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic [15:0] counterValue,
	input wire logic timerTick,
	input wire logic overflowEvt,
	input wire logic [15:0] compareAValue,
	input wire logic [15:0] compareBValue,
	input wire logic [3:0] waveformMode,
	input wire logic forceCompareA,
	input wire logic forceCompareB,
	input wire logic globalIrqEn,
	input wire logic [3:0] vectorAck,
	input wire logic [1:0] capturePin,
	input wire logic comparatorOut,
	input wire logic comparatorCaptureSel,
	input wire logic noiseCancelEn,
	input wire logic captureRising,
	input wire logic [1:0] extClkPin,
	input wire logic compareAWave,
	input wire logic compareBWave,
	output logic irqCapture,
	output logic irqCompareB,
	output logic irqCompareA,
	output logic irqOverflow,
	output logic [15:0] captureValue,
	output logic captureIsTop,
	output logic prescalerReset,
	output logic pinRouteSel,
	output logic extClk,
	output logic [1:0] compareAPin,
	output logic [1:0] compareBPin,
	output logic forcedMatchA,
	output logic forcedMatchB
);
	if (NC_SAMPLES < 2 || NC_SAMPLES > 16) begin : g_chk
		$error("NC_SAMPLES must be 2 to 16");
	end

	function automatic logic usesCapTop(input tmcap_pkg::tmcap_mode_t m);
		usesCapTop = (m == `TMCAP_WGM_TOP_A) || (m == `TMCAP_WGM_TOP_B) ||
			(m == `TMCAP_WGM_TOP_C) || (m == `TMCAP_WGM_TOP_D);
	endfunction : usesCapTop

	function automatic tmcap_pkg::tmcap_route_t routeOut(input logic sel, input logic v);
		routeOut = sel ? {v, 1'b0} : {1'b0, v};
	endfunction : routeOut

	// Register file state
	tmcap_pkg::tmcap_word_t cap_q;
	tmcap_pkg::tmcap_word_t cap_d;
	tmcap_pkg::tmcap_byte_t temp_q;
	tmcap_pkg::tmcap_byte_t temp_d;
	tmcap_pkg::tmcap_byte_t flags_q;
	tmcap_pkg::tmcap_byte_t flags_d;
	tmcap_pkg::tmcap_byte_t mask_q;
	tmcap_pkg::tmcap_byte_t mask_d;
	logic sync_q;
	logic sync_d;
	logic route_q;
	logic route_d;
	logic psr_q;
	logic psr_d;
	tmcap_pkg::tmcap_byte_t rd_q;
	tmcap_pkg::tmcap_byte_t rd_d;

	// Event path state
	logic pendA_q;
	logic pendA_d;
	logic pendB_q;
	logic pendB_d;
	logic [3:0] irq_q;
	logic [3:0] irq_d;
	logic top_q;
	logic top_d;
	logic [1:0] fmatch_q;
	logic [1:0] fmatch_d;
	logic ext_q;
	logic ext_d;
	logic [1:0] pinA_q;
	logic [1:0] pinA_d;
	logic [1:0] pinB_q;
	logic [1:0] pinB_d;

	// Combinational helpers
	logic capSrc;
	logic capEvt;
	logic wrCapLo;
	logic wrCapHi;
	logic wrFlags;
	logic wrMask;
	logic wrGtc;
	logic rdCapLo;
	tmcap_pkg::tmcap_byte_t setVec;
	tmcap_pkg::tmcap_byte_t clrVec;
	tmcap_pkg::tmcap_byte_t ackVec;
	tmcap_pkg::tmcap_byte_t gtcView;

	always_comb begin
		capSrc = capturePin[route_q];
		if (comparatorCaptureSel)
			capSrc = comparatorOut;
	end

	tmcap_capfront #(
		.NC_SAMPLES(NC_SAMPLES)
	) u_front (
		.core_clk(core_clk),
		.nrst(nrst),
		.capIn(capSrc),
		.ncEn(noiseCancelEn),
		.rising(captureRising),
		.capEvt(capEvt)
	);

	assign wrCapLo = regWr && (regAddr == `TMCAP_OFS_CAP_LO);
	assign wrCapHi = regWr && (regAddr == `TMCAP_OFS_CAP_HI);
	assign wrFlags = regWr && (regAddr == `TMCAP_OFS_FLAGS);
	assign wrMask = regWr && (regAddr == `TMCAP_OFS_MASK);
	assign wrGtc = regWr && (regAddr == `TMCAP_OFS_GTC);
	assign rdCapLo = regRd && (regAddr == `TMCAP_OFS_CAP_LO);

	// Capture value and shared high-byte latch
	always_comb begin
		cap_d = cap_q;
		temp_d = temp_q;
		if (wrCapHi)
			temp_d = regWrData;
		if (rdCapLo)
			temp_d = cap_q[15:8];
		if (wrCapLo)
			cap_d = {temp_q, regWrData};
		// hardware capture wins over software write
		if (capEvt && !usesCapTop(waveformMode))
			cap_d = counterValue;
	end

	// Compare match pending, one timer tick deep
	always_comb begin
		pendA_d = pendA_q;
		pendB_d = pendB_q;
		if (timerTick) begin
			pendA_d = (counterValue == compareAValue);
			pendB_d = (counterValue == compareBValue);
		end
		// forced strobes only reach waveform unit
		fmatch_d = {forceCompareB, forceCompareA};
	end

	// Flag set, clear and interrupt requests
	always_comb begin
		setVec = '0;
		setVec[`TMCAP_BIT_CAP] = capEvt && !usesCapTop(waveformMode);
		if (usesCapTop(waveformMode) && timerTick && counterValue == cap_q)
			setVec[`TMCAP_BIT_CAP] = 1'b1;
		setVec[`TMCAP_BIT_CMPB] = timerTick && pendB_q;
		setVec[`TMCAP_BIT_CMPA] = timerTick && pendA_q;
		setVec[`TMCAP_BIT_OVF] = overflowEvt;
		ackVec = '0;
		ackVec[`TMCAP_BIT_CAP] = vectorAck[3];
		ackVec[`TMCAP_BIT_CMPB] = vectorAck[2];
		ackVec[`TMCAP_BIT_CMPA] = vectorAck[1];
		ackVec[`TMCAP_BIT_OVF] = vectorAck[0];
		clrVec = ackVec | (wrFlags ? regWrData : '0);
		// Set wins so an event during clear is kept
		flags_d = ((flags_q & ~clrVec) | setVec) & `TMCAP_IRQ_IMPL;
		mask_d = wrMask ? (regWrData & `TMCAP_IRQ_IMPL) : mask_q;
		irq_d = '0;
		irq_d[3] = globalIrqEn && mask_q[`TMCAP_BIT_CAP] && flags_q[`TMCAP_BIT_CAP];
		irq_d[2] = globalIrqEn && mask_q[`TMCAP_BIT_CMPB] && flags_q[`TMCAP_BIT_CMPB];
		irq_d[1] = globalIrqEn && mask_q[`TMCAP_BIT_CMPA] && flags_q[`TMCAP_BIT_CMPA];
		irq_d[0] = globalIrqEn && mask_q[`TMCAP_BIT_OVF] && flags_q[`TMCAP_BIT_OVF];
	end

	// General control: sync hold, route and prescaler reset
	always_comb begin
		sync_d = sync_q;
		route_d = route_q;
		psr_d = psr_q && sync_q;
		if (wrGtc) begin
			sync_d = regWrData[`TMCAP_BIT_SYNC];
			route_d = regWrData[`TMCAP_BIT_ROUTE];
			// zero sync drops reset next cycle
			psr_d = regWrData[`TMCAP_BIT_PSR];
		end
		gtcView = '0;
		gtcView[`TMCAP_BIT_SYNC] = sync_q;
		gtcView[`TMCAP_BIT_ROUTE] = route_q;
		gtcView[`TMCAP_BIT_PSR] = psr_q;
	end

	// Pin routing and top selection
	always_comb begin
		ext_d = extClkPin[route_q];
		pinA_d = routeOut(route_q, compareAWave);
		pinB_d = routeOut(route_q, compareBWave);
		top_d = usesCapTop(waveformMode);
	end

	// Read data, valid only the cycle after the strobe
	always_comb begin
		rd_d = '0;
		if (regRd) begin
			case (regAddr)
				`TMCAP_OFS_CAP_LO: rd_d = cap_q[7:0];
				`TMCAP_OFS_CAP_HI: rd_d = temp_q;
				`TMCAP_OFS_FLAGS: rd_d = flags_q;
				`TMCAP_OFS_MASK: rd_d = mask_q;
				`TMCAP_OFS_GTC: rd_d = gtcView & `TMCAP_GTC_IMPL;
				default: rd_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cap_q <= `TMCAP_RST_WORD;
			temp_q <= `TMCAP_RST_BYTE;
		end else begin
			cap_q <= cap_d;
			temp_q <= temp_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pendA_q <= 1'b0;
			pendB_q <= 1'b0;
			fmatch_q <= '0;
		end else begin
			pendA_q <= pendA_d;
			pendB_q <= pendB_d;
			fmatch_q <= fmatch_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flags_q <= `TMCAP_RST_BYTE;
			mask_q <= `TMCAP_RST_BYTE;
			irq_q <= '0;
		end else begin
			flags_q <= flags_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sync_q <= 1'b0;
			route_q <= 1'b0;
			psr_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			route_q <= route_d;
			psr_q <= psr_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			top_q <= 1'b0;
			ext_q <= 1'b0;
			pinA_q <= '0;
			pinB_q <= '0;
		end else begin
			top_q <= top_d;
			ext_q <= ext_d;
			pinA_q <= pinA_d;
			pinB_q <= pinB_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_q <= `TMCAP_RST_BYTE;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign regRdData = rd_q;
	assign irqCapture = irq_q[3];
	assign irqCompareB = irq_q[2];
	assign irqCompareA = irq_q[1];
	assign irqOverflow = irq_q[0];
	assign captureValue = cap_q;
	assign captureIsTop = top_q;
	assign prescalerReset = psr_q;
	assign pinRouteSel = route_q;
	assign extClk = ext_q;
	assign compareAPin = pinA_q;
	assign compareBPin = pinB_q;
	assign forcedMatchA = fmatch_q[0];
	assign forcedMatchB = fmatch_q[1];
endmodule : tmcap_core
`default_nettype wire

// >>> rtl/tmcap_params.svh
`ifndef TMCAP_PARAMS_SVH
`define TMCAP_PARAMS_SVH

// Register offsets
`define TMCAP_OFS_CAP_LO 6'h22
`define TMCAP_OFS_CAP_HI 6'h23
`define TMCAP_OFS_FLAGS 6'h2a
`define TMCAP_OFS_MASK 6'h2b
`define TMCAP_OFS_GTC 6'h2f

// Reset values
`define TMCAP_RST_BYTE 8'h00
`define TMCAP_RST_WORD 16'h0000

// Flag and mask bit positions
`define TMCAP_BIT_CAP 5
`define TMCAP_BIT_CMPB 2
`define TMCAP_BIT_CMPA 1
`define TMCAP_BIT_OVF 0

// General control bit positions
`define TMCAP_BIT_SYNC 7
`define TMCAP_BIT_ROUTE 1
`define TMCAP_BIT_PSR 0

// Implemented bits
`define TMCAP_IRQ_IMPL 8'h27
`define TMCAP_GTC_IMPL 8'h83

// Waveform modes that use the capture value as top
`define TMCAP_WGM_TOP_A 4'h8
`define TMCAP_WGM_TOP_B 4'ha
`define TMCAP_WGM_TOP_C 4'hc
`define TMCAP_WGM_TOP_D 4'he

// Noise canceller sample count
`define TMCAP_NC_SAMPLES 4

`endif

// >>> rtl/tmcap_pkg.sv
package tmcap_pkg;
	typedef logic [7:0] tmcap_byte_t;
	typedef logic [15:0] tmcap_word_t;
	typedef logic [3:0] tmcap_mode_t;
	typedef logic [1:0] tmcap_route_t;
endpackage : tmcap_pkg

// >>> rtl/tmcap_capfront.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmcap_params.svh"

module tmcap_capfront #(
	parameter int NC_SAMPLES = `TMCAP_NC_SAMPLES
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic capIn,
	input wire logic ncEn,
	input wire logic rising,
	output logic capEvt
);
	logic [NC_SAMPLES-1:0] hist_q;
	logic [NC_SAMPLES-1:0] hist_d;
	logic level_q;
	logic level_d;
	logic evt_q;
	logic evt_d;

	always_comb begin
		hist_d = {hist_q[NC_SAMPLES-2:0], capIn};
		level_d = level_q;
		// Canceller trades latency for glitch immunity
		if (ncEn) begin
			if (&hist_q)
				level_d = 1'b1;
			else if (~|hist_q)
				level_d = 1'b0;
		end else begin
			level_d = hist_q[0];
		end
		evt_d = rising ? (level_d & ~level_q) : (~level_d & level_q);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			hist_q <= '0;
			level_q <= 1'b0;
			evt_q <= 1'b0;
		end else begin
			hist_q <= hist_d;
			level_q <= level_d;
			evt_q <= evt_d;
		end
	end

	assign capEvt = evt_q;
endmodule : tmcap_capfront
`default_nettype wire

// >>> test/tmcap_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module tmcap_core_props (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic [3:0] waveformMode,
	input wire logic globalIrqEn,
	input wire logic irqCapture,
	input wire logic irqOverflow,
	input wire logic captureIsTop,
	input wire logic prescalerReset,
	input wire logic pinRouteSel,
	input wire logic compareAWave,
	input wire logic [1:0] compareAPin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	flag_bits_a: assert property (
		$past(regRd) && $past(regAddr) == 6'h2a |-> (regRdData & 8'hd8) == 8'h00)
		else $error("flag reserved bits set");
	ctl_bits_a: assert property (
		$past(regRd) && $past(regAddr) == 6'h2f |-> (regRdData & 8'h7c) == 8'h00)
		else $error("control reserved bits set");
	route_bit_a: assert property (
		regWr && regAddr == 6'h2f |=> pinRouteSel == $past(regWrData[1]))
		else $error("route bit not taken");
	pin_route_a: assert property (
		$past(nrst) |=> compareAPin == ($past(pinRouteSel) ? {$past(compareAWave), 1'b0}
			: {1'b0, $past(compareAWave)}))
		else $error("compare pin routing wrong");
	// Later writes may legally change the level, hence the escape
	psr_pulse_a: assert property (
		regWr && regAddr == 6'h2f && !regWrData[7] |=> prescalerReset == $past(regWrData[0])
			##1 (!prescalerReset || $past(regWr)))
		else $error("prescaler reset not self clearing");
	psr_hold_a: assert property (
		regWr && regAddr == 6'h2f && regWrData[7] && regWrData[0]
			|=> prescalerReset ##1 (prescalerReset || $past(regWr)))
		else $error("prescaler reset not held");
	top_mode_a: assert property (
		1 |=> captureIsTop == ($past(waveformMode) inside {4'h8, 4'ha, 4'hc, 4'he}))
		else $error("top mode decode wrong");
	irq_cap_a: assert property (!globalIrqEn |=> !irqCapture)
		else $error("capture irq without global enable");
	irq_ovf_a: assert property (!globalIrqEn |=> !irqOverflow)
		else $error("overflow irq without global enable");
endmodule : tmcap_core_props
bind tmcap_core tmcap_core_props i_props (.core_clk, .nrst, .regAddr, .regWrData, .regWr,
	.regRd, .regRdData, .waveformMode, .globalIrqEn, .irqCapture, .irqOverflow,
	.captureIsTop, .prescalerReset, .pinRouteSel, .compareAWave, .compareAPin);
`default_nettype wire

// >>> test/tmcap_cnt_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmcap_cnt_model (
	input wire logic core_clk,
	input wire logic run,
	input wire logic load,
	input wire logic [15:0] loadVal,
	output logic [15:0] counterValue,
	output logic timerTick,
	output logic overflowEvt
);
	// Ticks every cycle while running; a stopped counter holds its value, so captures still copy that value
	always_ff @(posedge core_clk) begin
		timerTick <= run;
		overflowEvt <= run && counterValue == 16'hffff;
		if (load)
			counterValue <= loadVal;
		else if (run)
			counterValue <= counterValue + 16'h0001;
	end
endmodule : tmcap_cnt_model
`default_nettype wire

// >>> test/tb_tmcap_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tmcap_core;
	logic core_clk, nrst, regWr, regRd, run, load, timerTick, overflowEvt;
	logic forceCompareA, forceCompareB, globalIrqEn, comparatorOut, comparatorCaptureSel;
	logic noiseCancelEn, captureRising, compareAWave, compareBWave, irqCapture, irqCompareB;
	logic irqCompareA, irqOverflow, captureIsTop, prescalerReset, pinRouteSel, extClk;
	logic forcedMatchA, forcedMatchB;
	logic [5:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic [15:0] counterValue, compareAValue, compareBValue, captureValue, loadVal;
	logic [15:0] seed = 16'h0007;
	logic [3:0] waveformMode, vectorAck;
	logic [1:0] capturePin, extClkPin, compareAPin, compareBPin;
	logic [5:0] addrs[6] = '{6'h22, 6'h23, 6'h2a, 6'h2b, 6'h2f, 6'h30};
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int capM, flagsM;
	logic routeM;
	logic [6:0] pinExp;
	tmcap_core #(.NC_SAMPLES(3)) i_tmcap_core (
		.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .counterValue(counterValue),
		.timerTick(timerTick), .overflowEvt(overflowEvt), .compareAValue(compareAValue),
		.compareBValue(compareBValue), .waveformMode(waveformMode),
		.forceCompareA(forceCompareA), .forceCompareB(forceCompareB),
		.globalIrqEn(globalIrqEn), .vectorAck(vectorAck), .capturePin(capturePin),
		.comparatorOut(comparatorOut), .comparatorCaptureSel(comparatorCaptureSel),
		.noiseCancelEn(noiseCancelEn), .captureRising(captureRising),
		.extClkPin(extClkPin), .compareAWave(compareAWave), .compareBWave(compareBWave),
		.irqCapture(irqCapture), .irqCompareB(irqCompareB), .irqCompareA(irqCompareA),
		.irqOverflow(irqOverflow), .captureValue(captureValue), .captureIsTop(captureIsTop),
		.prescalerReset(prescalerReset), .pinRouteSel(pinRouteSel), .extClk(extClk),
		.compareAPin(compareAPin), .compareBPin(compareBPin),
		.forcedMatchA(forcedMatchA), .forcedMatchB(forcedMatchB)
	);
	tmcap_cnt_model i_tmcap_cnt_model (
		.core_clk(core_clk), .run(run), .load(load), .loadVal(loadVal),
		.counterValue(counterValue), .timerTick(timerTick), .overflowEvt(overflowEvt)
	);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 chk({8'h00, regRdData}, {8'h00, e});
		@(posedge core_clk);
	endtask : rd
	task automatic runFrom(input logic [15:0] v, input int n);
		load <= 1'b1;
		loadVal <= v;
		@(posedge core_clk);
		load <= 1'b0;
		run <= (n > 0);
		repeat (n + 2) @(posedge core_clk);
		run <= 1'b0;
		@(posedge core_clk);
	endtask : runFrom
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Random wave and clock pins keep the routing muxes busy
	always @(posedge core_clk) begin
		seed <= lfsr(seed);
		compareAWave <= seed[1];
		compareBWave <= seed[2];
		extClkPin <= seed[4:3];
		// Routed pins and forced strobes trail their inputs by one flop
		if (nrst)
			chk({extClk, compareAPin, compareBPin, forcedMatchA, forcedMatchB}, pinExp);
		routeM <= nrst && ((regWr && regAddr == 6'h2f) ? regWrData[1] : routeM);
		pinExp <= !nrst ? 7'h00 : {extClkPin[routeM],
			(routeM ? {compareAWave, 1'b0} : {1'b0, compareAWave}),
			(routeM ? {compareBWave, 1'b0} : {1'b0, compareBWave}),
			forceCompareA, forceCompareB};
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		{nrst, regWr, regRd, run, forceCompareA, forceCompareB, globalIrqEn} = '0;
		{regAddr, regWrData, waveformMode, vectorAck, capturePin, extClkPin} = '0;
		{comparatorCaptureSel, noiseCancelEn, compareAWave, compareBWave} = '0;
		{comparatorOut, captureRising, load} = 3'b111;
		{compareAValue, compareBValue, loadVal} = {16'h0010, 16'h0012, 16'h0000};
		repeat (20) @(posedge core_clk);
		nrst <= 1'b1;
		load <= 1'b0;
		@(posedge core_clk);
		foreach (addrs[i]) rd(addrs[i], 8'h00);
		wr(6'h2b, 8'hff);
		rd(6'h2b, 8'h27);
		wr(6'h2f, 8'h7e);
		rd(6'h2f, 8'h02);
		globalIrqEn <= 1'b1;
		capM = seed;
		runFrom(seed, 0);
		capturePin <= 2'b01;
		repeat (10) @(posedge core_clk);
		chk(captureValue, 16'h0000);
		capturePin <= 2'b11;
		repeat (10) @(posedge core_clk);
		flagsM = 8'h20;
		chk(captureValue, capM[15:0]);
		rd(6'h22, capM[7:0]);
		rd(6'h23, capM[15:8]);
		chk(irqCapture, 1'b1);
		wr(6'h2a, 8'h00);
		rd(6'h2a, flagsM[7:0]);
		wr(6'h2a, 8'h20);
		rd(6'h2a, 8'h00);
		forceCompareA <= 1'b1;
		forceCompareB <= 1'b1;
		@(posedge core_clk);
		{forceCompareA, forceCompareB} <= 2'b00;
		repeat (3) @(posedge core_clk);
		rd(6'h2a, 8'h00);
		runFrom(16'h000c, 12);
		rd(6'h2a, 8'h06);
		chk({irqCompareA, irqCompareB}, 2'b11);
		vectorAck <= 4'b0110;
		@(posedge core_clk);
		vectorAck <= 4'b0000;
		rd(6'h2a, 8'h00);
		runFrom(16'hfffe, 3);
		rd(6'h2a, 8'h01);
		chk(irqOverflow, 1'b1);
		wr(6'h2a, 8'h01);
		wr(6'h23, 8'h5a);
		chk(captureValue, capM[15:0]);
		wr(6'h22, 8'hc3);
		chk(captureValue, 16'h5ac3);
		waveformMode <= 4'h8;
		runFrom(16'h5ab0, 24);
		chk(captureIsTop, 1'b1);
		rd(6'h2a, 8'h20);
		wr(6'h2a, 8'h20);
		waveformMode <= 4'h0;
		{comparatorCaptureSel, noiseCancelEn, captureRising} <= 3'b110;
		capM = seed;
		runFrom(seed, 0);
		repeat (8) @(posedge core_clk);
		comparatorOut <= 1'b0;
		repeat (12) @(posedge core_clk);
		chk(captureValue, capM[15:0]);
		rd(6'h2a, 8'h20);
		wr(6'h2f, 8'h81);
		repeat (5) @(posedge core_clk);
		chk(prescalerReset, 1'b1);
		rd(6'h2f, 8'h81);
		wr(6'h2f, 8'h00);
		chk(prescalerReset, 1'b0);
		wr(6'h2f, 8'h01);
		rd(6'h2f, 8'h00);
		end_of_test();
	end
endmodule : tb_tmcap_core
`default_nettype wire
